// ### inc/emps_pkg.sv
package emps_pkg;
	localparam logic [3:0] TXD_IDLE    = 4'h0;
	localparam logic       LOW         = 1'b0;
	localparam logic       HIGH        = 1'b1;
	localparam int         CLK_HZ      = 50000000;
	localparam int         MDC_HZ      = 2500000;
	localparam int         MDC_HALF    = CLK_HZ / (2 * MDC_HZ);
	localparam logic [4:0] MDC_HALF_M1 = 5'(MDC_HALF - 1);
	localparam logic [1:0] SYNC_IDLE   = 2'h0;
endpackage

// ### src/emps_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ------------------------------------------------------------
module emps_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// The stages are deliberately not cleared by reset.
	// The strap level must reach the port logic while reset is still held.
	always_ff @(posedge i_clock)
	begin
		stage1 <= i_async;
		stage2 <= stage1;
	end

	assign o_sync = stage2;
endmodule

// ### src/emps_port.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// External MII port select
// ------------------------------------------------------------
// Notes on behaviour
// - Transmit nibble goes to the PHY, held low when internal PHY selected.
// - Transmit enable marks valid data, held low when internal PHY selected.
// - With management select set, MDIO is the bidirectional management data line.
// - MDC carries the management clock when selected, low otherwise.
// - MDIO is released to high impedance when management select is clear.
// - MDIO doubles as a strap telling whether an external PHY is fitted.
module emps_port (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_internal_phy_sel,
	input  wire logic       i_ext_mgmt_port_select,
	input  wire logic [3:0] i_mac_txd,
	input  wire logic       i_mac_tx_en,
	input  wire logic       i_mac_mdio_out,
	input  wire logic       i_mac_mdio_oe,
	input  wire logic       i_tx_clk,
	input  wire logic       i_rx_clk,
	input  wire logic [3:0] i_rxd,
	input  wire logic       i_rx_dv,
	input  wire logic       i_rx_er,
	input  wire logic       i_col,
	input  wire logic       i_crs,
	input  wire logic       i_mdio,
	output logic      [3:0] o_txd,
	output logic            o_tx_en,
	output logic            o_mdc,
	output logic            o_mdio,
	output logic            o_mdio_oe,
	output logic      [3:0] o_mac_rxd,
	output logic            o_mac_rx_dv,
	output logic            o_mac_rx_er,
	output logic            o_mac_col,
	output logic            o_mac_crs,
	output logic            o_mac_mdio_in,
	output logic            o_mac_rx_strobe,
	output logic            o_mac_tx_strobe,
	output logic            o_external_phy_strap
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] pins_sync;

	emps_sync #(.W(12)) u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_tx_clk, i_rx_clk, i_rxd, i_rx_dv, i_rx_er, i_col, i_crs, i_mdio, 1'b0}),
		.o_sync  (pins_sync)
	);

	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_RUN   = 2'h1
	} emps_state_t;

	typedef struct packed {
		emps_state_t state;
		logic        strap;
		logic [3:0]  txd;
		logic        tx_en;
		logic        mdc;
		logic        mdio;
		logic        mdio_oe;
		logic [4:0]  mdc_cnt;
		logic        tx_clk_d;
		logic        rx_clk_d;
		logic [3:0]  rxd;
		logic        rx_dv;
		logic        rx_er;
		logic        col;
		logic        crs;
		logic        mdio_in;
		logic        rx_strobe;
		logic        tx_strobe;
	} emps_regs_t;

	emps_regs_t r;
	emps_regs_t next_r;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		next_r.tx_clk_d  = pins_sync[11];
		next_r.rx_clk_d  = pins_sync[10];
		// PHY clocks are sampled, so 25 MHz needs the 50 MHz clock at its edge of capability.
		next_r.rx_strobe = pins_sync[10] & ~r.rx_clk_d;
		next_r.tx_strobe = pins_sync[11] & ~r.tx_clk_d;
		if (next_r.rx_strobe)
		begin
			next_r.rxd   = pins_sync[9:6];
			next_r.rx_dv = pins_sync[5];
			next_r.rx_er = pins_sync[4];
		end
		next_r.col     = pins_sync[3];
		next_r.crs     = pins_sync[2];
		next_r.mdio_in = pins_sync[1];
		case (r.state)
			ST_RESET:
			begin
				next_r.state = ST_RUN;
			end
			ST_RUN:
			begin
				next_r.state = ST_RUN;
			end
			default:
			begin
				next_r.state = ST_RESET;
			end
		endcase
		if (i_internal_phy_sel)
		begin
			next_r.txd   = emps_pkg::TXD_IDLE;
			next_r.tx_en = emps_pkg::LOW;
		end
		else
		begin
			next_r.txd   = i_mac_txd;
			next_r.tx_en = i_mac_tx_en;
		end
		if (i_ext_mgmt_port_select && r.state == ST_RUN)
		begin
			next_r.mdio    = i_mac_mdio_out;
			next_r.mdio_oe = i_mac_mdio_oe;
			if (r.mdc_cnt == emps_pkg::MDC_HALF_M1)
			begin
				next_r.mdc_cnt = '0;
				next_r.mdc     = ~r.mdc;
			end
			else
			begin
				next_r.mdc_cnt = r.mdc_cnt + 5'h1;
			end
		end
		else
		begin
			next_r.mdio    = emps_pkg::LOW;
			next_r.mdio_oe = emps_pkg::LOW;
			next_r.mdc     = emps_pkg::LOW;
			next_r.mdc_cnt = '0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			r <= '0;
			// The strap is caught by a clocked sample while reset is held; MDIO is undriven then.
			r.strap <= pins_sync[1];
		end
		else
		begin
			r <= next_r;
		end
	end

	assign o_txd                = r.txd;
	assign o_tx_en              = r.tx_en;
	assign o_mdc                = r.mdc;
	assign o_mdio               = r.mdio;
	assign o_mdio_oe            = r.mdio_oe;
	assign o_mac_rxd            = r.rxd;
	assign o_mac_rx_dv          = r.rx_dv;
	assign o_mac_rx_er          = r.rx_er;
	assign o_mac_col            = r.col;
	assign o_mac_crs            = r.crs;
	assign o_mac_mdio_in        = r.mdio_in;
	assign o_mac_rx_strobe      = r.rx_strobe;
	assign o_mac_tx_strobe      = r.tx_strobe;
	assign o_external_phy_strap = r.strap;
endmodule

// ### verif/emps_monitor.sv
`timescale 1ns/1ps
module emps_monitor (
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic       i_internal_phy_sel,
	input wire logic       i_ext_mgmt_port_select,
	input wire logic       i_mac_mdio_out,
	input wire logic       i_mac_mdio_oe,
	input wire logic [3:0] o_txd,
	input wire logic       o_tx_en,
	input wire logic       o_mdc,
	input wire logic       o_mdio,
	input wire logic       o_mdio_oe,
	input wire logic       o_external_phy_strap
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_run; !$past(i_rst) && !$past(i_rst, 2); endsequence
	property p_txd; (s_run and $past(i_internal_phy_sel)) |-> o_txd == 4'h0; endproperty
	a_txd: assert property (p_txd) else $error("txd not low");
	property p_tx_en; (s_run and $past(i_internal_phy_sel)) |-> !o_tx_en; endproperty
	a_tx_en: assert property (p_tx_en) else $error("tx_en not low");
	property p_mdio; (s_run and $past(i_ext_mgmt_port_select)) |->
		o_mdio_oe == $past(i_mac_mdio_oe) && o_mdio == $past(i_mac_mdio_out); endproperty
	a_mdio: assert property (p_mdio) else $error("mdio not passed");
	property p_mdio_off; (s_run and !$past(i_ext_mgmt_port_select)) |-> !o_mdio_oe; endproperty
	a_mdio_off: assert property (p_mdio_off) else $error("mdio driven");
	property p_mdc_off; (s_run and !$past(i_ext_mgmt_port_select)) |-> !o_mdc; endproperty
	a_mdc_off: assert property (p_mdc_off) else $error("mdc not low");
	property p_strap; !$past(i_rst) |-> $stable(o_external_phy_strap); endproperty
	a_strap: assert property (p_strap) else $error("strap moved");
endmodule
bind emps_port emps_monitor emps_monitor_inst (.*);

// ### verif/emps_phy_model.sv
`timescale 1ns/1ps
module emps_phy_model (
	input  wire logic       i_go,
	output logic            o_clk = 1'b0,
	output logic      [3:0] o_rxd = 4'hf,
	output logic      [3:0] o_flags = 4'h0
);
	// Flags are receive valid, receive error, collision and carrier, in that order.
	always #80 o_clk = ~o_clk;
	always @(posedge i_go)
	begin
		for (int i = 1; i < 5; i++)
		begin
			@(negedge o_clk);
			o_rxd = 4'(i);
			o_flags = {1'b1, i == 3, i == 4, 1'b1};
		end
		@(negedge o_clk);
		o_rxd = 4'hb;
		o_flags = 4'h0;
	end
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0, rst = 1'b1, isel = 1'b1, msel = 1'b0, ten = 1'b0, moe = 1'b0, strap = 1'b1, go = 1'b0, stb = 1'b0;
	logic [3:0]  txi = 4'h0, txd, rxd, fl, mrxd;
	logic [15:0] sr = 16'h0;
	logic [2:0]  seen = 3'h0;
	logic        txen, mdc, mdo, mdoe, pclk, mdv, mer, mcol, mcrs, mdin, rstb, pstrap;
	int          mismatches = 0, cmp_count = 0, n, ntx = 0;
	logic        tstb;
	wire logic   mdio = mdoe ? mdo : strap;
	always #10 clk = ~clk;
	emps_phy_model emps_phy_model_inst (.i_go(go), .o_clk(pclk), .o_rxd(rxd), .o_flags(fl));
	emps_port emps_port_inst (.i_clock(clk), .i_rst(rst), .i_internal_phy_sel(isel), .i_ext_mgmt_port_select(msel),
		.i_mac_txd(txi), .i_mac_tx_en(ten), .i_mac_mdio_out(moe), .i_mac_mdio_oe(moe), .i_tx_clk(pclk), .i_rx_clk(pclk),
		.i_rxd(rxd), .i_rx_dv(fl[3]), .i_rx_er(fl[2]), .i_col(fl[1]), .i_crs(fl[0]), .i_mdio(mdio), .o_txd(txd),
		.o_tx_en(txen), .o_mdc(mdc), .o_mdio(mdo), .o_mdio_oe(mdoe), .o_mac_rxd(mrxd), .o_mac_rx_dv(mdv),
		.o_mac_rx_er(mer), .o_mac_col(mcol), .o_mac_crs(mcrs), .o_mac_mdio_in(mdin), .o_mac_rx_strobe(rstb),
		.o_mac_tx_strobe(tstb), .o_external_phy_strap(pstrap));
	always @(posedge clk)
	begin
		stb <= rstb;
		if (stb && mdv === 1'b1)
			sr <= {sr[11:0], mrxd};
		seen <= seen | {mer, mcol, mcrs};
		ntx <= ntx + int'(tstb === 1'b1);
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic t_tx;
		isel = 1'b0; txi = 4'h5; ten = 1'b1; step(2);
		chk("txd", 16'h5, txd);
		chk("tx_en", 16'h1, txen);
		isel = 1'b1; txi = 4'ha; step(2);
		chk("txd", 16'h0, txd);
		chk("tx_en", 16'h0, txen);
		ten = 1'b0; $display("test tx done");
	endtask
	task automatic t_mgmt;
		logic p;
		msel = 1'b1; moe = 1'b1; step(4);
		chk("mdio", 16'h3, {mdoe, mdo});
		chk("mdio_in", 16'h1, mdin);
		n = 0;
		repeat (40)
		begin
			p = mdc; step(1); n += (mdc !== p);
		end
		chk("mdc edges", 16'h4, 16'(n));
		msel = 1'b0; step(2);
		chk("mdio_oe", 16'h0, mdoe);
		chk("mdc", 16'h0, mdc);
		moe = 1'b0; $display("test mgmt done");
	endtask
	task automatic t_rx;
		n = ntx;
		go = 1'b1; step(60);
		chk("tx strobes", 16'h1, 16'(ntx - n >= 7));
		chk("rx nibbles", 16'h1234, sr);
		chk("er col crs", 16'h7, seen);
		go = 1'b0; $display("test rx done");
	endtask
	task automatic t_strap;
		chk("strap", 16'h1, pstrap);
		strap = 1'b0; step(6);
		chk("strap held", 16'h1, pstrap);
		rst = 1'b1; step(4); rst = 1'b0; step(2);
		chk("strap", 16'h0, pstrap);
		$display("test strap done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		step(4); rst = 1'b0; step(2);
		t_tx; t_mgmt; t_rx; t_strap;
		report_and_stop;
	end
	initial
	begin
		#20000; mismatches++;
		report_and_stop;
	end
endmodule
